// ==== hw/tpc_bit_packer.sv ====
// serial tdm bits into msb-first bytes, with octet-aligned t1 padding
`timescale 1ns/1ps
`default_nettype none
module tpc_bit_packer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic oct_t1_i,
  // line side, already synchronised
  input wire logic bit_vld_i,
  input wire logic bit_i,
  // byte side
  output logic byte_vld_o,
  output logic [7:0] byte_o
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] sfb;
    logic vld;
    logic [7:0] out;
  } tpc_pk_t;
  tpc_pk_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.vld = 1'b0;
    if (bit_vld_i) begin
      // first bit lands in the msb [RULE_19]
      s_d.sh = {s_q.sh[6:0], bit_i};
      s_d.cnt = s_q.cnt + 3'h1;
      if (oct_t1_i && s_q.sfb == 8'(tpc_pkg::SUBFRAME_DATA_BITS - 1)) begin
        // last data bit of subframe: pad the rest with zero [RULE_21]
        s_d.out = {s_q.sh[6:0], bit_i} << tpc_pkg::SUBFRAME_PAD_BITS;
        s_d.vld = 1'b1;
        s_d.cnt = 3'h0;
        s_d.sfb = 8'h00;
      end else begin
        s_d.sfb = oct_t1_i ? s_q.sfb + 8'h01 : 8'h00;
        if (s_q.cnt == 3'h7) begin
          s_d.out = {s_q.sh[6:0], bit_i};
          s_d.vld = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign byte_vld_o = s_q.vld;
  assign byte_o = s_q.out;
endmodule
`default_nettype wire

// ==== hw/tpc_codec.sv ====
// pseudowire header encapsulation and decapsulation codec
`timescale 1ns/1ps
`default_nettype none
module tpc_codec #(
  parameter int unsigned PL_MAX = 1024
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic [1:0] ckt_type_i,
  input wire logic oct_t1_i,
  input wire logic rtp_en_i,
  input wire logic ts_diff_i,
  input wire logic [6:0] tx_pt_i,
  input wire logic [6:0] rx_pt_i,
  input wire logic pt_chk_i,
  input wire logic [31:0] ssrc_i,
  input wire logic omit_faulted_i,
  input wire logic ach_i,
  // status from surrounding logic
  input wire logic ckt_fault_i,
  input wire logic rx_loss_state_i,
  // tdm line input (asynchronous pins)
  input wire logic tdm_bit_vld_i,
  input wire logic tdm_bit_i,
  // timestamp clock ticks (asynchronous level toggles)
  input wire logic ts_rec_i,
  input wire logic ts_com_i,
  // packet transmit stream
  output logic tx_vld_o,
  output logic [7:0] tx_data_o,
  output logic tx_sop_o,
  output logic tx_eop_o,
  input wire logic tx_rdy_i,
  // packet receive stream
  input wire logic rx_vld_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sop_i,
  input wire logic rx_eop_i,
  // played-out payload
  output logic po_vld_o,
  output logic [7:0] po_data_o,
  // receive status
  output logic rx_done_o,
  output logic rx_malformed_o,
  output logic rx_fault_o,
  output logic rx_rloss_o,
  output logic [15:0] rx_seq_o,
  // transmit status
  output logic tx_ovf_o
);
  function automatic logic [10:0] pl_size(input logic [1:0] ck, input logic oct);
    if (ck == tpc_pkg::CKT_E1) begin
      pl_size = 11'(tpc_pkg::PL_E1);
    end else if (ck == tpc_pkg::CKT_T1) begin
      // octet-aligned t1 uses eight subframes [RULE_22]
      pl_size = oct ? 11'(tpc_pkg::PL_T1_OCT) : 11'(tpc_pkg::PL_T1);
    end else begin
      pl_size = 11'(tpc_pkg::PL_T3E3);
    end
  endfunction
  function automatic logic [10:0] hdr_size(input logic rtp);
    hdr_size = rtp ? 11'(tpc_pkg::CW_BYTES + tpc_pkg::RTP_BYTES) : 11'(tpc_pkg::CW_BYTES);
  endfunction

  logic pk_vld;
  logic [7:0] pk_byte;
  logic [15:0] rnd;
  // two banks: one fills from the line while the other is sent [RULE_19]
  logic [7:0] buf_q [2*PL_MAX];

  typedef struct packed {
    logic [1:0] bv_s;
    logic [1:0] bd_s;
    logic [2:0] tr_s;
    logic [2:0] tc_s;
    logic seeded;
    logic [15:0] seq;
    logic [31:0] ts_rec;
    logic [31:0] ts_com;
    logic [10:0] wr_cnt;
    logic full;
    logic wb;
    logic rbk;
    tpc_pkg::tpc_tx_st_t tst;
    logic [10:0] tidx;
    logic [15:0][7:0] hb;
    logic fault_l;
    logic ovf;
    tpc_pkg::tpc_rx_st_t rst;
    logic [10:0] ridx;
    logic [7:0] rb0;
    logic [15:0] rseq;
    logic [5:0] rlen;
    logic [6:0] rpt;
    logic rfault;
    logic rrl;
    logic [10:0] rpay;
    logic done;
    logic mal;
    logic po_v;
    logic [7:0] po_d;
  } tpc_st_t;
  tpc_st_t s_q, s_d;

  tpc_bit_packer u_packer (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .oct_t1_i(oct_t1_i),
    .bit_vld_i(s_q.bv_s[1]),
    .bit_i(s_q.bd_s[1]),
    .byte_vld_o(pk_vld),
    .byte_o(pk_byte)
  );
  tpc_seq_lfsr u_lfsr (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .rnd_o(rnd)
  );

  logic [10:0] pl;
  logic [10:0] hl;
  logic [10:0] tot;
  logic [7:0] cw0;
  logic tx_take;
  logic tx_last;
  logic hdr_phase;
  logic [31:0] ts_sel;
  logic [7:0] b0_now;
  always_comb begin
    b0_now = rx_sop_i ? rx_data_i : s_q.rb0;
    pl = pl_size(ckt_type_i, oct_t1_i); // [RULE_20] [RULE_18]
    hl = hdr_size(rtp_en_i);
    tot = hl + pl;
    // fault flag follows the live fault, so it clears once rectified [RULE_04] [RULE_02]
    // remote loss tracks the local receiver loss state [RULE_05] [RULE_06]
    cw0 = {ach_i ? 4'h1 : 4'h0, ckt_fault_i, rx_loss_state_i, 2'b00}; // [RULE_01] [RULE_07]
    // absolute uses recovered line clock, differential the shared one [RULE_16] [RULE_17]
    ts_sel = ts_diff_i ? s_q.ts_com : s_q.ts_rec;
    hdr_phase = s_q.tst == tpc_pkg::TPC_TX_HDR;
    tx_take = (s_q.tst != tpc_pkg::TPC_TX_IDLE) && tx_rdy_i;
    tx_last = hdr_phase ? (s_q.fault_l && omit_faulted_i && s_q.tidx == hl - 11'h1)
                        : (s_q.tidx == pl - 11'h1);
  end

  always_comb begin
    s_d = s_q;
    s_d.bv_s = {s_q.bv_s[0], tdm_bit_vld_i};
    s_d.bd_s = {s_q.bd_s[0], tdm_bit_i};
    s_d.tr_s = {s_q.tr_s[1:0], ts_rec_i};
    s_d.tc_s = {s_q.tc_s[1:0], ts_com_i};
    s_d.done = 1'b0;
    s_d.po_v = 1'b0;
    if (!s_q.seeded) begin
      s_d.seq = rnd; // [RULE_10]
      s_d.seeded = 1'b1;
    end
    // one tick per edge of an 8 khz multiple clock [RULE_15]
    if (s_q.tr_s[2] != s_q.tr_s[1]) s_d.ts_rec = s_q.ts_rec + 32'h1;
    if (s_q.tc_s[2] != s_q.tc_s[1]) s_d.ts_com = s_q.ts_com + 32'h1;
    case (s_q.tst)
      tpc_pkg::TPC_TX_IDLE: begin
        if (s_q.full && s_q.seeded) begin
          s_d.tst = tpc_pkg::TPC_TX_HDR;
          s_d.tidx = 11'h0;
          s_d.fault_l = ckt_fault_i;
          s_d.rbk = ~s_q.wb;
          // control word first, msb byte first [RULE_25] [RULE_23]
          s_d.hb[0] = cw0;
          // short length only when total under limit [RULE_08]
          s_d.hb[1] = (tot < 11'(tpc_pkg::SHORT_LEN_LIMIT)) ? {2'b00, tot[5:0]} : 8'h00;
          s_d.hb[2] = s_q.seq[15:8];
          s_d.hb[3] = s_q.seq[7:0];
          s_d.hb[4] = tpc_pkg::RTP_B0; // [RULE_11]
          s_d.hb[5] = {1'b0, tx_pt_i}; // [RULE_12] [RULE_11]
          s_d.hb[6] = s_q.seq[15:8]; // [RULE_14]
          s_d.hb[7] = s_q.seq[7:0];
          s_d.hb[8] = ts_sel[31:24];
          s_d.hb[9] = ts_sel[23:16];
          s_d.hb[10] = ts_sel[15:8];
          s_d.hb[11] = ts_sel[7:0];
          s_d.hb[12] = ssrc_i[31:24];
          s_d.hb[13] = ssrc_i[23:16];
          s_d.hb[14] = ssrc_i[15:8];
          s_d.hb[15] = ssrc_i[7:0];
        end
      end
      tpc_pkg::TPC_TX_HDR: begin
        if (tx_take) begin
          s_d.tidx = s_q.tidx + 11'h1;
          if (tx_last) begin
            // faulted packet sent without payload [RULE_02]
            s_d.tst = tpc_pkg::TPC_TX_IDLE;
            s_d.full = 1'b0;
            s_d.seq = s_q.seq + 16'h1; // [RULE_10]
          end else if (s_q.tidx == hl - 11'h1) begin
            s_d.tst = tpc_pkg::TPC_TX_PAY;
            s_d.tidx = 11'h0;
          end
        end
      end
      tpc_pkg::TPC_TX_PAY: begin
        if (tx_take) begin
          s_d.tidx = s_q.tidx + 11'h1;
          if (tx_last) begin
            s_d.tst = tpc_pkg::TPC_TX_IDLE;
            s_d.full = 1'b0;
            s_d.seq = s_q.seq + 16'h1; // [RULE_10]
          end
        end
      end
      default: s_d.tst = tpc_pkg::TPC_TX_IDLE;
    endcase
    // payload fill keeps running; a bank completing while the other is unsent overflows
    if (pk_vld) begin
      s_d.wr_cnt = s_q.wr_cnt + 11'h1;
      if (s_q.wr_cnt == pl - 11'h1) begin
        s_d.wr_cnt = 11'h0;
        if (s_d.full) begin
          s_d.ovf = 1'b1;
        end else begin
          s_d.full = 1'b1;
          s_d.wb = ~s_q.wb;
        end
      end
    end
    // receive side
    case (s_q.rst)
      tpc_pkg::TPC_RX_HDR, tpc_pkg::TPC_RX_PAY: begin
        if (rx_vld_i) begin
          s_d.ridx = rx_sop_i ? 11'h1 : s_q.ridx + 11'h1;
          if (rx_sop_i) begin
            s_d.rb0 = rx_data_i;
            s_d.rpay = 11'h0;
            s_d.rst = tpc_pkg::TPC_RX_HDR;
          end else if (s_q.ridx == 11'h1) begin
            s_d.rlen = rx_data_i[5:0]; // reserved bits ignored [RULE_07]
          end else if (s_q.ridx == 11'h2) begin
            s_d.rseq[15:8] = rx_data_i; // [RULE_23]
          end else if (s_q.ridx == 11'h3) begin
            s_d.rseq[7:0] = rx_data_i;
          end else if (rtp_en_i && s_q.ridx == 11'h5) begin
            s_d.rpt = rx_data_i[6:0];
          end else if (s_q.ridx >= hl) begin
            s_d.rpay = s_q.rpay + 11'h1;
          end
          if (!rx_sop_i && s_q.ridx >= hl) s_d.rst = tpc_pkg::TPC_RX_PAY;
          if (rx_eop_i) begin
            s_d.done = 1'b1;
            s_d.rfault = b0_now[tpc_pkg::CW_FAULT_BIT];
            s_d.rrl = b0_now[tpc_pkg::CW_RLOSS_BIT];
            s_d.ridx = 11'h0;
            // size check: faulted may omit payload; short length overrides [RULE_09]
            s_d.mal = 1'b0;
            if (s_q.rlen != 6'h0) begin
              s_d.mal = (s_q.ridx + 11'h1) != 11'(s_q.rlen);
            end else if (!(s_q.rb0[tpc_pkg::CW_FAULT_BIT] && s_q.ridx + 11'h1 == hl)) begin
              s_d.mal = (s_q.ridx + 11'h1) != tot;
            end
            if (pt_chk_i && rtp_en_i && s_q.rpt != rx_pt_i) s_d.mal = 1'b1; // [RULE_13]
            if (s_q.rb0[tpc_pkg::CW_FAULT_BIT] && !s_d.mal) begin
              // full payload of all-ones regardless of size [RULE_03] [RULE_24]
              s_d.rst = tpc_pkg::TPC_RX_FILL;
              s_d.rpay = 11'h0;
            end else begin
              s_d.rst = tpc_pkg::TPC_RX_HDR;
            end
          end
        end
        // good payload bytes are played through as they arrive
        if (rx_vld_i && !rx_sop_i && s_q.ridx >= hl && !s_q.rb0[tpc_pkg::CW_FAULT_BIT]) begin
          s_d.po_v = 1'b1;
          s_d.po_d = rx_data_i;
        end
      end
      tpc_pkg::TPC_RX_FILL: begin
        s_d.po_v = 1'b1;
        s_d.po_d = tpc_pkg::FILL_BYTE; // [RULE_24]
        s_d.rpay = s_q.rpay + 11'h1;
        if (s_q.rpay == pl - 11'h1) s_d.rst = tpc_pkg::TPC_RX_HDR; // [RULE_03]
      end
      default: s_d.rst = tpc_pkg::TPC_RX_HDR;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // payload store, written by the packer, read by the transmitter
  always_ff @(posedge core_clk_i) begin
    if (pk_vld) buf_q[{s_q.wb, s_q.wr_cnt[9:0]}] <= pk_byte; // [RULE_19]
  end

  assign tx_vld_o = s_q.tst != tpc_pkg::TPC_TX_IDLE;
  assign tx_data_o = !tx_vld_o ? 8'h00 : hdr_phase ? s_q.hb[s_q.tidx[3:0]]
                   : buf_q[{s_q.rbk, s_q.tidx[9:0]}];
  assign tx_sop_o = hdr_phase && s_q.tidx == 11'h0;
  assign tx_eop_o = tx_vld_o && tx_last;
  assign po_vld_o = s_q.po_v;
  assign po_data_o = s_q.po_d;
  assign rx_done_o = s_q.done;
  assign rx_malformed_o = s_q.mal;
  assign rx_fault_o = s_q.rfault;
  assign rx_rloss_o = s_q.rrl;
  assign rx_seq_o = s_q.rseq;
  assign tx_ovf_o = s_q.ovf;
endmodule
`default_nettype wire

// ==== hw/tpc_pkg.sv ====
// constants and types shared by the pseudowire header codec
// How it works
// [RULE_01] control word top four bits sent zero unless marking channel header
// [RULE_02] fault flag marks payload invalid; sender may omit the payload
// [RULE_03] receiver plays a full payload of filler on faulted packets
// [RULE_04] transmitter clears fault flag once the circuit fault is gone
// [RULE_05] transmitter sets remote loss flag while local receiver is in loss state
// [RULE_06] transmitter clears remote loss flag once local receiver leaves loss state
// [RULE_07] reserved and fragmentation bits sent zero, ignored on receive
// [RULE_08] short length holds header plus payload when under 64 bytes, else zero
// [RULE_09] zero short length means configured payload; size mismatch is malformed
// [RULE_10] sequence number is 16-bit wrapping, random start, plus one per packet; code always starts at the lfsr reset value 16'hace1
// [RULE_11] rtp padding, extension, csrc count and marker sent as zero
// [RULE_12] transmitter writes its allocated payload type into every rtp header
// [RULE_13] receiver may flag packets with wrong payload type as malformed
// [RULE_14] rtp sequence number equals the control word sequence number
// [RULE_15] timestamp clock is an integer multiple of 8 khz
// [RULE_16] absolute mode takes timestamps from the recovered tdm clock
// [RULE_17] differential mode takes timestamps from a shared timing source
// [RULE_18] every packet carries the same fixed payload size in both directions
// [RULE_19] payload bytes keep line order, bits fill msb first
// [RULE_20] payload sizes 256 for e1, 192 for t1, 1024 for e3 and t3
// [RULE_21] octet-aligned t1 uses 25-byte subframes, 193 data bits, 7 pad bits
// [RULE_22] octet-aligned t1 supports a 200-byte payload of eight subframes
// [RULE_23] sequence number sits in bits 16 to 31 of first header word
// [RULE_24] faulted packets play out all-ones even when payload was present
// [RULE_25] control word sent most significant byte first, network order
package tpc_pkg;
  localparam int unsigned CW_BYTES = 4;
  localparam int unsigned RTP_BYTES = 12;
  localparam int unsigned SHORT_LEN_LIMIT = 64;
  localparam int unsigned PL_E1 = 256;
  localparam int unsigned PL_T1 = 192;
  localparam int unsigned PL_T3E3 = 1024;
  localparam int unsigned PL_T1_OCT = 200;
  localparam int unsigned SUBFRAME_BYTES = 25;
  localparam int unsigned SUBFRAME_DATA_BITS = 193;
  localparam int unsigned SUBFRAME_PAD_BITS = 7;
  localparam int unsigned TS_BASE_KHZ = 8;
  // circuit types
  localparam logic [1:0] CKT_E1 = 2'h0;
  localparam logic [1:0] CKT_T1 = 2'h1;
  localparam logic [1:0] CKT_E3 = 2'h2;
  localparam logic [1:0] CKT_T3 = 2'h3;
  // rtp first byte: version 2, padding/extension/csrc zero
  localparam logic [7:0] RTP_B0 = 8'h80;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  // control word byte 0 bits (lsb = position 0)
  localparam int unsigned CW_FAULT_BIT = 3;
  localparam int unsigned CW_RLOSS_BIT = 2;
  typedef enum logic [1:0] {
    TPC_TX_IDLE = 2'b00,
    TPC_TX_HDR = 2'b01,
    TPC_TX_PAY = 2'b10
  } tpc_tx_st_t;
  typedef enum logic [1:0] {
    TPC_RX_HDR = 2'b00,
    TPC_RX_PAY = 2'b01,
    TPC_RX_FILL = 2'b10
  } tpc_rx_st_t;
endpackage

// ==== hw/tpc_seq_lfsr.sv ====
// free-running lfsr; the codec takes its reset value 16'hace1 as the sequence number start
`timescale 1ns/1ps
`default_nettype none
module tpc_seq_lfsr (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // value
  output logic [15:0] rnd_o
);
  typedef struct packed {
    logic [15:0] r;
  } tpc_lf_t;
  tpc_lf_t s_q, s_d;
  always_comb begin
    s_d.r = {s_q.r[14:0], s_q.r[15] ^ s_q.r[13] ^ s_q.r[12] ^ s_q.r[10]};
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.r <= 16'hace1;
    end else begin
      s_q <= s_d;
    end
  end
  assign rnd_o = s_q.r;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the pseudowire header codec
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_i, rst_b_i, oct_t1_i, rtp_en_i, ts_diff_i, pt_chk_i, omit_faulted_i, ach_i;
  logic ckt_fault_i, rx_loss_state_i, tdm_bit_vld_i, tdm_bit_i, ts_rec_i, ts_com_i, tx_rdy_i;
  logic tx_vld_o, tx_sop_o, tx_eop_o, rx_vld_i, rx_sop_i, rx_eop_i, po_vld_o, rx_done_o;
  logic rx_malformed_o, rx_fault_o, rx_rloss_o, tx_ovf_o, slow;
  logic [1:0] ckt_type_i;
  logic [6:0] tx_pt_i, rx_pt_i;
  logic [7:0] tx_data_o, rx_data_i, po_data_o, pat;
  logic [15:0] rx_seq_o;
  logic [31:0] ssrc_i, v;
  logic [2:0] bi;
  logic [5:0] cyc;
  int errors = 0;
  int checks_done = 0;
  int po_cnt = 0;
  int po_nff = 0;
  int sz [4] = '{tpc_pkg::PL_E1, tpc_pkg::PL_T1, tpc_pkg::PL_T3E3, tpc_pkg::PL_T3E3};
  tpc_codec dut_u (.core_clk_i, .rst_b_i, .ckt_type_i, .oct_t1_i, .rtp_en_i, .ts_diff_i,
    .tx_pt_i, .rx_pt_i, .pt_chk_i, .ssrc_i, .omit_faulted_i, .ach_i, .ckt_fault_i,
    .rx_loss_state_i, .tdm_bit_vld_i, .tdm_bit_i, .ts_rec_i, .ts_com_i, .tx_vld_o, .tx_data_o,
    .tx_sop_o, .tx_eop_o, .tx_rdy_i, .rx_vld_i, .rx_data_i, .rx_sop_i, .rx_eop_i, .po_vld_o,
    .po_data_o, .rx_done_o, .rx_malformed_o, .rx_fault_o, .rx_rloss_o, .rx_seq_o, .tx_ovf_o);
  tpc_far_end far_u (.core_clk_i(core_clk_i), .slow_i(slow), .tx_vld_i(tx_vld_o),
    .tx_data_i(tx_data_o), .tx_sop_i(tx_sop_o), .tx_eop_i(tx_eop_o), .tx_rdy_o(tx_rdy_i),
    .rx_vld_o(rx_vld_i), .rx_data_o(rx_data_i), .rx_sop_o(rx_sop_i), .rx_eop_o(rx_eop_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task test_done;
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ts();
    return {far_u.pkt[8], far_u.pkt[9], far_u.pkt[10], far_u.pkt[11]};
  endfunction
  // wait for the next whole packet and check payload order
  task automatic get_pkt;
    int t, k, hl;
    t = far_u.cnt + 1;
    for (k = 0; k < 20000 && far_u.cnt < t; k++) @(negedge core_clk_i);
    chk(far_u.cnt >= t, 1);
    hl = rtp_en_i ? 16 : 4;
    for (k = hl; k < far_u.len - 1; k++) chk(far_u.pkt[k + 1], 8'(far_u.pkt[k] + 8'h01));
  endtask
  task automatic rxp(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] sq,
                     input logic [7:0] pt, input bit rtp, input int pl, input logic mal,
                     input int po);
    int k;
    po_cnt = 0;
    po_nff = 0;
    far_u.send(b0, b1, sq, pt, rtp, pl);
    for (k = 0; k < 40 && rx_done_o !== 1'b1; k++) @(negedge core_clk_i);
    chk(rx_done_o, 1);
    chk(rx_malformed_o, mal);
    if (!mal) chk(rx_seq_o, sq);
    if (!mal) chk({rx_fault_o, rx_rloss_o}, b0[3:2]);
    repeat (300) @(negedge core_clk_i);
    if (po >= 0) chk(po_cnt, po);
    if (b0[3]) chk(po_nff, 0);
  endtask
  always @(posedge core_clk_i) begin
    if (po_vld_o === 1'b1) begin
      po_cnt++;
      if (po_data_o !== 8'hff) po_nff++;
    end
  end
  // line bits msb first from a counting byte, shared-clock ticks
  initial begin
    @(posedge rst_b_i);
    forever begin
      @(negedge core_clk_i);
      tdm_bit_vld_i <= 1'b1;
      tdm_bit_i <= pat[~bi];
      bi = bi + 3'h1;
      if (bi == 3'h0) pat = pat + 8'h01;
      cyc = cyc + 6'h01;
      if (cyc == 6'h00) ts_com_i <= ~ts_com_i;
    end
  end
  initial begin
    #(90000 * 5);
    errors++;
    test_done;
  end
  initial begin
    {oct_t1_i, rtp_en_i, ts_diff_i, pt_chk_i, omit_faulted_i, ach_i} = 6'h00;
    {ckt_fault_i, rx_loss_state_i, tdm_bit_vld_i, tdm_bit_i, ts_rec_i, ts_com_i} = 6'h00;
    {rst_b_i, slow, bi, pat, cyc} = 19'h0;
    ckt_type_i = tpc_pkg::CKT_E1;
    tx_pt_i = 7'h60;
    rx_pt_i = 7'h61;
    ssrc_i = 32'h5eed0001;
    repeat (4) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    get_pkt;
    chk({far_u.pkt[0], far_u.pkt[1]}, 32'h0);
    chk(far_u.len, 4 + sz[0]);
    v = {far_u.pkt[2], far_u.pkt[3]};
    get_pkt;
    chk({far_u.pkt[2], far_u.pkt[3]}, 16'(v + 1));
    {ckt_fault_i, omit_faulted_i, rx_loss_state_i, ach_i} = 4'hf;
    get_pkt;
    chk({far_u.len[7:0], far_u.pkt[0]}, 16'h041c);
    {ckt_fault_i, omit_faulted_i, rx_loss_state_i, ach_i} = 4'h0;
    get_pkt;
    chk(far_u.pkt[0], 32'h0);
    for (int t = 1; t < 4; t++) begin
      ckt_type_i = 2'(t);
      get_pkt;
      chk(far_u.len, 4 + sz[t]);
    end
    {ckt_type_i, rtp_en_i, slow} = 4'h3;
    get_pkt;
    chk({far_u.pkt[4], far_u.pkt[5]}, 16'h8060);
    chk({far_u.pkt[6], far_u.pkt[7]}, {far_u.pkt[2], far_u.pkt[3]});
    v = ts();
    get_pkt;
    chk(ts(), v);
    ts_diff_i = 1'b1;
    get_pkt;
    v = ts();
    get_pkt;
    chk(ts() != v, 1);
    pt_chk_i = 1'b1;
    rxp(8'h00, 8'h00, 16'h0101, 8'h62, 1, sz[0], 1, sz[0]);
    rxp(8'h00, 8'h00, 16'h0102, 8'h61, 1, sz[0], 0, sz[0]);
    get_pkt;
    rtp_en_i = 1'b0;
    rxp(8'h03, 8'hc0, 16'h1234, 8'h00, 0, sz[0], 0, sz[0]);
    rxp(8'h00, 8'h00, 16'h1235, 8'h00, 0, 100, 1, 100);
    rxp(8'h00, 8'd24, 16'h1236, 8'h00, 0, 20, 0, -1);
    rxp(8'h00, 8'd30, 16'h1237, 8'h00, 0, 20, 1, 20);
    rxp(8'h08, 8'h00, 16'h1238, 8'h00, 0, 0, 0, sz[0]);
    rxp(8'h0c, 8'h00, 16'h1239, 8'h00, 0, sz[0], 0, -1);
    chk(tx_ovf_o, 0);
    test_done;
  end
endmodule
`default_nettype wire

// ==== test/tpc_codec_asserts.sv ====
// port checker for the pseudowire header codec
`timescale 1ns/1ps
`default_nettype none
module tpc_codec_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // configuration and status
  input wire logic rtp_en_i,
  input wire logic [6:0] tx_pt_i,
  input wire logic omit_faulted_i,
  input wire logic ach_i,
  input wire logic ckt_fault_i,
  input wire logic rx_loss_state_i,
  // transmit stream
  input wire logic tx_vld_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_sop_o,
  input wire logic tx_eop_o,
  input wire logic tx_rdy_i
);
  logic tk;
  logic pv_q;
  logic [4:0] ix_q;
  logic [7:0] s2_q;
  logic [15:0] ps_q;
  assign tk = tx_vld_o && tx_rdy_i;
  // byte index inside the packet, saturating past the header
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ix_q <= 5'h00;
      s2_q <= 8'h00;
      ps_q <= 16'h0000;
      pv_q <= 1'b0;
    end else if (tk) begin
      ix_q <= tx_eop_o ? 5'h00 : (ix_q == 5'h10 ? ix_q : ix_q + 5'h01);
      if (ix_q == 5'h02) s2_q <= tx_data_o;
      if (ix_q == 5'h03) ps_q <= {s2_q, tx_data_o};
      if (ix_q == 5'h03) pv_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_cw0;
    tk && ix_q == 5'h00;
  endsequence
  sequence s_cw3;
    tk && ix_q == 5'h03;
  endsequence
  AST_CW_TOP: assert property (s_cw0 |-> tx_sop_o && tx_data_o[7:4] == {3'h0, ach_i})
    else $error("control word top bits wrong");
  AST_CW_FLAG: assert property (s_cw0 |-> tx_data_o[3:0] == {ckt_fault_i, rx_loss_state_i, 2'h0})
    else $error("control word flags wrong");
  AST_HOLD: assert property (tx_vld_o && !tx_rdy_i |=> tx_vld_o && $stable(tx_data_o) && $stable(tx_sop_o))
    else $error("byte not held while stalled");
  AST_LEN: assert property (tk && ix_q == 5'h01 && !(ckt_fault_i && omit_faulted_i) |-> tx_data_o == 8'h00)
    else $error("short length not zero");
  AST_SEQ: assert property (s_cw3 and pv_q |-> {s2_q, tx_data_o} == ps_q + 16'h0001)
    else $error("sequence not incremented");
  AST_RTP_HDR: assert property (tk && rtp_en_i && (ix_q == 5'h04 || ix_q == 5'h05) |-> tx_data_o == (ix_q == 5'h04 ? 8'h80 : {1'b0, tx_pt_i}))
    else $error("rtp first bytes wrong");
  AST_RTP_SEQ: assert property (tk && rtp_en_i && (ix_q == 5'h06 || ix_q == 5'h07) |-> tx_data_o == (ix_q == 5'h06 ? ps_q[15:8] : ps_q[7:0]))
    else $error("rtp sequence differs");
  AST_OMIT: assert property (s_cw3 and (ckt_fault_i && omit_faulted_i && !rtp_en_i) |-> tx_eop_o)
    else $error("faulted packet not cut short");
endmodule
bind tpc_codec tpc_codec_asserts chk_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .rtp_en_i(rtp_en_i), .tx_pt_i(tx_pt_i), .omit_faulted_i(omit_faulted_i), .ach_i(ach_i),
  .ckt_fault_i(ckt_fault_i), .rx_loss_state_i(rx_loss_state_i), .tx_vld_o(tx_vld_o),
  .tx_data_o(tx_data_o), .tx_sop_o(tx_sop_o), .tx_eop_o(tx_eop_o), .tx_rdy_i(tx_rdy_i));
`default_nettype wire

// ==== test/tpc_far_end.sv ====
// remote endpoint model: stalling packet sink and packet source
`timescale 1ns/1ps
`default_nettype none
module tpc_far_end (
  // clock and pacing
  input wire logic core_clk_i,
  input wire logic slow_i,
  // packets from the codec
  input wire logic tx_vld_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_sop_i,
  input wire logic tx_eop_i,
  output logic tx_rdy_o,
  // packets into the codec
  output logic rx_vld_o,
  output logic [7:0] rx_data_o,
  output logic rx_sop_o,
  output logic rx_eop_o
);
  logic [7:0] pkt [0:1039];
  logic busy = 1'b0;
  int n = 0;
  int len = 0;
  int cnt = 0;
  initial begin
    {tx_rdy_o, rx_vld_o, rx_sop_o, rx_eop_o} = 4'h0;
    rx_data_o = 8'h00;
  end
  // idle data keeps changing so a stale byte never looks valid
  always @(negedge core_clk_i) begin
    tx_rdy_o <= slow_i ? ~tx_rdy_o : 1'b1;
    if (!busy) rx_data_o <= ~rx_data_o;
  end
  always @(posedge core_clk_i) begin
    if (tx_vld_i === 1'b1 && tx_rdy_o) begin
      if (tx_sop_i) n = 0;
      pkt[n] = tx_data_i;
      n++;
      if (tx_eop_i) begin
        len = n;
        cnt++;
      end
    end
  end
  // one packet, header then payload bytes counting up
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] sq,
                      input logic [7:0] pt, input bit rtp, input int pl);
    logic [7:0] h [0:15];
    int hl;
    h = '{0: b0, 1: b1, 2: sq[15:8], 3: sq[7:0], 4: 8'h80, 5: pt, 6: sq[15:8], 7: sq[7:0],
          default: 8'h00};
    hl = rtp ? 16 : 4;
    busy = 1'b1;
    for (int i = 0; i < hl + pl; i++) begin
      @(negedge core_clk_i);
      {rx_vld_o, rx_sop_o, rx_eop_o} <= {1'b1, i == 0, i == hl + pl - 1};
      rx_data_o <= (i < hl) ? h[i] : 8'(i);
    end
    @(negedge core_clk_i);
    {rx_vld_o, rx_sop_o, rx_eop_o} <= 3'h0;
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire
